// ===== fcr_cfg.svh
`ifndef FCR_CFG_SVH
`define FCR_CFG_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define FCR_CMD_SET_READ_NV   8'h65
`define FCR_CMD_SET_READ_V0   8'hc0
`define FCR_CMD_SET_READ_V1   8'h63
`define FCR_CMD_WR_FUNC       8'h42

// ----------------------------------------------------------------
// function register fields and reset values
// ----------------------------------------------------------------
`define FCR_FN_RST_DIS_BIT    0
`define FCR_FN_BOTTOM_BIT     1
`define FCR_FN_PGM_SUS_BIT    2
`define FCR_FN_ERS_SUS_BIT    3
`define FCR_FN_LOCK_LSB       4
`define FCR_FN_OTP_MASK       8'hf3
`define FCR_FN_RESET          8'h00

// ----------------------------------------------------------------
// read register fields and reset values
// ----------------------------------------------------------------
`define FCR_RD_BURST_LSB      0
`define FCR_RD_WRAP_BIT       2
`define FCR_RD_DUMMY_LSB      3
`define FCR_RD_ROLE_BIT       7
`define FCR_RD_RESET          8'h00
`define FCR_BURST_BASE        7'h08

`endif

// ===== fcr_pkg.sv
package fcr_pkg;

  typedef struct packed {
    logic [3:0] info_row_lock;
    logic       erase_paused_flag;
    logic       program_paused_flag;
    logic       protect_range_bottom;
    logic       reset_pin_disable;
  } fcr_func_t;

  typedef struct packed {
    logic       shared_pin_role_sel;
    logic [3:0] dummy_count;
    logic       wrap_at_burst_en;
    logic [1:0] burst_len;
  } fcr_read_t;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic [7:0] data;
  } fcr_byte_t;

  typedef enum logic [1:0] {
    FCR_POWER_UP,
    FCR_IDLE,
    FCR_WAIT_DATA,
    FCR_IGNORE
  } fcr_state_t;

endpackage

// ===== fcr_spi_rx.sv
`timescale 1ns/100ps
module fcr_spi_rx
  import fcr_pkg::*;
(
  input  wire logic      sys_clk_i,
  input  wire logic      sys_rst_i,
  input  wire logic      link_sclk_i,
  input  wire logic      link_cs_n_i,
  input  wire logic      link_si_i,
  output fcr_byte_t      rx_o
);

  // ----------------------------------------------------------------
  // two-stage synchronisers, second stage is the only reader
  // ----------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       sclk_prev;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic       first_pend;
  logic [2:0] next_bit_cnt;
  logic [6:0] next_shift;
  logic       next_first_pend;
  fcr_byte_t  next_rx;
  logic       sclk_rise;

  always_ff @(posedge sys_clk_i)
  begin
    sync_a <= {link_sclk_i, link_cs_n_i, link_si_i};
    sync_b <= sync_a;
  end

  // ----------------------------------------------------------------
  // mode 0 shift, msb first; cs high aborts any partial byte
  // ----------------------------------------------------------------
  always_comb
  begin
    sclk_rise       = sync_b[2] & ~sclk_prev;
    next_bit_cnt    = bit_cnt;
    next_shift      = shift;
    next_first_pend = first_pend;
    next_rx         = '0;
    if (sync_b[1])
    begin
      next_bit_cnt    = 3'h0;
      next_first_pend = 1'b1;
    end
    else if (sclk_rise)
    begin
      next_bit_cnt = bit_cnt + 3'h1;
      next_shift   = {shift[5:0], sync_b[0]};
      if (bit_cnt == 3'h7)
      begin
        next_rx.valid   = 1'b1;
        next_rx.first   = first_pend;
        next_rx.data    = {shift, sync_b[0]};
        next_first_pend = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      sclk_prev  <= 1'b0;
      bit_cnt    <= 3'h0;
      shift      <= 7'h00;
      first_pend <= 1'b1;
      rx_o       <= '0;
    end
    else
    begin
      sclk_prev  <= sync_b[2];
      bit_cnt    <= next_bit_cnt;
      shift      <= next_shift;
      first_pend <= next_first_pend;
      rx_o       <= next_rx;
    end
  end

endmodule

// ===== fcr_regs.sv
`timescale 1ns/100ps
`include "fcr_cfg.svh"
module fcr_regs
  import fcr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       link_sclk_i,
  input  wire logic       link_cs_n_i,
  input  wire logic       link_si_i,
  input  wire logic       has_dedicated_reset_i,
  input  wire logic       reset_disable_default_i,
  input  wire logic       quad_lines_on_i,
  input  wire logic       qpi_mode_i,
  input  wire logic       program_busy_i,
  input  wire logic       erase_busy_i,
  input  wire logic       suspend_cmd_i,
  input  wire logic       resume_cmd_i,
  input  wire logic [1:0] row_program_sel_i,
  output fcr_func_t       func_o,
  output fcr_read_t       read_o,
  output fcr_read_t       read_nv_o,
  output logic            dedicated_reset_active_o,
  output logic            shared_pin_is_reset_o,
  output logic            shared_pin_is_data_o,
  output logic            row_program_blocked_o,
  output logic [3:0]      dummy_cycles_o,
  output logic            wrap_at_burst_o,
  output logic [6:0]      burst_bytes_o,
  output logic            ready_o
);

  // ----------------------------------------------------------------
  // link receiver
  // ----------------------------------------------------------------
  fcr_byte_t rx;

  fcr_spi_rx u_rx (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .link_sclk_i (link_sclk_i),
    .link_cs_n_i (link_cs_n_i),
    .link_si_i   (link_si_i),
    .rx_o        (rx)
  );

  function automatic logic is_read_cmd(input logic [7:0] op);
    is_read_cmd = (op == `FCR_CMD_SET_READ_NV) ||
                  (op == `FCR_CMD_SET_READ_V0) ||
                  (op == `FCR_CMD_SET_READ_V1) ||
                  (op == `FCR_CMD_WR_FUNC);
  endfunction

  // ----------------------------------------------------------------
  // command sequencing and register state
  // ----------------------------------------------------------------
  fcr_state_t state;
  fcr_state_t next_state;
  logic [7:0] opcode;
  logic [7:0] next_opcode;
  fcr_func_t  func;
  fcr_func_t  next_func;
  fcr_read_t  rd_v;
  fcr_read_t  next_rd_v;
  fcr_read_t  rd_nv;
  fcr_read_t  next_rd_nv;
  logic [7:0] otp_set;

  always_comb
  begin
    next_state = state;
    next_opcode = opcode;
    next_func = func;
    next_rd_v = rd_v;
    next_rd_nv = rd_nv;
    otp_set = 8'h00;
    case (state)
      FCR_POWER_UP:
      begin
        // strap sampled after release, never inside reset
        next_func.reset_pin_disable = reset_disable_default_i;
        next_rd_v = rd_nv;
        next_state = FCR_IDLE;
      end
      FCR_IDLE:
      begin
        if (rx.valid)
        begin
          next_opcode = rx.data;
          if (rx.first && is_read_cmd(rx.data))
          begin
            next_state = FCR_WAIT_DATA;
          end
          else
          begin
            next_state = FCR_IGNORE;
          end
        end
      end
      FCR_WAIT_DATA:
      begin
        if (rx.valid && rx.first)
        begin
          next_opcode = rx.data;
          next_state = is_read_cmd(rx.data) ? FCR_WAIT_DATA : FCR_IGNORE;
        end
        else if (rx.valid)
        begin
          next_state = FCR_IGNORE;
          case (opcode)
            `FCR_CMD_SET_READ_NV: next_rd_nv = fcr_read_t'(rx.data);
            `FCR_CMD_SET_READ_V0: next_rd_v = fcr_read_t'(rx.data);
            `FCR_CMD_SET_READ_V1: next_rd_v = fcr_read_t'(rx.data);
            // only ones are ever or-ed in, suspend flags masked off
            default: otp_set = rx.data & `FCR_FN_OTP_MASK;
          endcase
        end
      end
      FCR_IGNORE:
      begin
        if (rx.valid && rx.first)
        begin
          next_opcode = rx.data;
          next_state = is_read_cmd(rx.data) ? FCR_WAIT_DATA : FCR_IGNORE;
        end
      end
      default: next_state = FCR_IDLE;
    endcase
    next_func = fcr_func_t'(8'(next_func) | otp_set);
    // suspend sets win over a resume in the same cycle
    if (resume_cmd_i)
    begin
      next_func.program_paused_flag = 1'b0;
      next_func.erase_paused_flag = 1'b0;
    end
    if (suspend_cmd_i && program_busy_i)
    begin
      next_func.program_paused_flag = 1'b1;
    end
    if (suspend_cmd_i && erase_busy_i)
    begin
      next_func.erase_paused_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state  <= FCR_POWER_UP;
      opcode <= 8'h00;
      func   <= fcr_func_t'(`FCR_FN_RESET);
      rd_v   <= fcr_read_t'(`FCR_RD_RESET);
      rd_nv  <= fcr_read_t'(`FCR_RD_RESET);
    end
    else
    begin
      state  <= next_state;
      opcode <= next_opcode;
      func   <= next_func;
      rd_v   <= next_rd_v;
      rd_nv  <= next_rd_nv;
    end
  end

  // ----------------------------------------------------------------
  // decoded controls, registered so every output is a flop
  // ----------------------------------------------------------------
  logic       next_ded_rst;
  logic       next_pin_reset;
  logic       next_pin_data;
  logic       next_row_block;
  logic [6:0] next_burst;

  always_comb
  begin
    next_pin_data  = quad_lines_on_i | qpi_mode_i;
    next_ded_rst   = has_dedicated_reset_i &
                     ~next_func.reset_pin_disable;
    // dedicated-reset parts keep hold unless the pin was retired or quad/qpi makes it a data line
    if (next_pin_data)
    begin
      next_pin_reset = 1'b0;
    end
    else if (has_dedicated_reset_i)
    begin
      next_pin_reset = next_func.reset_pin_disable;
    end
    else
    begin
      next_pin_reset = next_rd_v.shared_pin_role_sel;
    end
    next_row_block = next_func.info_row_lock[row_program_sel_i];
    next_burst = `FCR_BURST_BASE << next_rd_v.burst_len;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      func_o                   <= '0;
      read_o                   <= '0;
      read_nv_o                <= '0;
      dedicated_reset_active_o <= 1'b0;
      shared_pin_is_reset_o    <= 1'b0;
      shared_pin_is_data_o     <= 1'b0;
      row_program_blocked_o    <= 1'b0;
      dummy_cycles_o           <= 4'h0;
      wrap_at_burst_o          <= 1'b0;
      burst_bytes_o            <= `FCR_BURST_BASE;
      ready_o                  <= 1'b0;
    end
    else
    begin
      func_o                   <= next_func;
      read_o                   <= next_rd_v;
      read_nv_o                <= next_rd_nv;
      dedicated_reset_active_o <= next_ded_rst;
      shared_pin_is_reset_o    <= next_pin_reset;
      shared_pin_is_data_o     <= next_pin_data;
      row_program_blocked_o    <= next_row_block;
      dummy_cycles_o           <= next_rd_v.dummy_count;
      wrap_at_burst_o          <= next_rd_v.wrap_at_burst_en;
      burst_bytes_o            <= next_burst;
      ready_o                  <= (next_state != FCR_POWER_UP);
    end
  end

endmodule

// ===== fcr_host_model.sv
`timescale 1ns/100ps
module fcr_host_model
(
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end
  // ----------------------------------------------------------------
  // one frame: opcode then data, msb first, mode 0
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] op, input logic [7:0] d);
    logic [15:0] w;
    w = {op, d};
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      si_o = w[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    // released line shows the inverse so a stale bit cannot pass
    si_o = ~si_o;
  endtask
endmodule

// ===== fcr_regs_sva.sv
`timescale 1ns/100ps
module fcr_regs_sva
  import fcr_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       has_dedicated_reset_i,
  input wire logic       quad_lines_on_i,
  input wire logic       qpi_mode_i,
  input wire logic       program_busy_i,
  input wire logic       erase_busy_i,
  input wire logic       suspend_cmd_i,
  input wire logic       resume_cmd_i,
  input wire fcr_func_t  func_o,
  input wire fcr_read_t  read_o,
  input wire logic       dedicated_reset_active_o,
  input wire logic       shared_pin_is_reset_o,
  input wire logic       shared_pin_is_data_o,
  input wire logic [3:0] dummy_cycles_o,
  input wire logic       wrap_at_burst_o,
  input wire logic [6:0] burst_bytes_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  burst_map_a:
    assert property (burst_bytes_o == (7'h08 << read_o.burst_len))
      else $error("burst size wrong");
  field_follow_a:
    assert property (dummy_cycles_o == read_o.dummy_count &&
      wrap_at_burst_o == read_o.wrap_at_burst_en)
      else $error("dummy or wrap output wrong");
  otp_sticky_a:
    assert property (1'b1 |=> ((func_o & $past(func_o) & 8'hf3) ==
      ($past(func_o) & 8'hf3)))
      else $error("one-time bit cleared");
  pgm_suspend_a:
    assert property (suspend_cmd_i && program_busy_i |=>
      func_o.program_paused_flag)
      else $error("program pause flag not set");
  ers_suspend_a:
    assert property (suspend_cmd_i && erase_busy_i |=>
      func_o.erase_paused_flag)
      else $error("erase pause flag not set");
  resume_clear_a:
    assert property (resume_cmd_i && !suspend_cmd_i |=>
      !(func_o.program_paused_flag || func_o.erase_paused_flag))
      else $error("pause flag not cleared");
  data_pin_a:
    assert property ((quad_lines_on_i || qpi_mode_i) [*2] |->
      shared_pin_is_data_o && !shared_pin_is_reset_o)
      else $error("shared pin not data line");
  ded_reset_a:
    assert property (has_dedicated_reset_i [*2] |->
      dedicated_reset_active_o == !func_o.reset_pin_disable)
      else $error("dedicated reset state wrong");
  hold_forced_a:
    assert property ((has_dedicated_reset_i &&
      !func_o.reset_pin_disable) [*2] |-> !shared_pin_is_reset_o)
      else $error("shared pin left as reset");
  cover property (suspend_cmd_i && program_busy_i);
  cover property (shared_pin_is_data_o);
  cover property (func_o.info_row_lock != 4'h0);
endmodule

// ===== tb.sv
`timescale 1ns/100ps
module tb
  import fcr_pkg::*;
;
  logic       clk, rst, ded, strap, quad, qpi, pb, eb, sus, res;
  logic [1:0] sel;
  wire        sclk, cs_n, si;
  fcr_func_t  func;
  fcr_read_t  rd, rdnv;
  logic       ded_act, pin_rst, pin_data, blk, wrap, rdy;
  logic [3:0] dum;
  logic [6:0] bb;
  logic [7:0] v;
  logic [7:0] vals [4] = '{8'h79, 8'h0f, 8'h84, 8'hd6};
  int         err_total = 0;
  int         checks = 0;
  fcr_host_model fcr_host_model_i (.clk_i(clk), .sclk_o(sclk),
    .cs_n_o(cs_n), .si_o(si));
  fcr_regs fcr_regs_i (.sys_clk_i(clk), .sys_rst_i(rst),
    .link_sclk_i(sclk), .link_cs_n_i(cs_n), .link_si_i(si),
    .has_dedicated_reset_i(ded), .reset_disable_default_i(strap),
    .quad_lines_on_i(quad), .qpi_mode_i(qpi), .program_busy_i(pb),
    .erase_busy_i(eb), .suspend_cmd_i(sus), .resume_cmd_i(res),
    .row_program_sel_i(sel), .func_o(func), .read_o(rd),
    .read_nv_o(rdnv), .dedicated_reset_active_o(ded_act),
    .shared_pin_is_reset_o(pin_rst), .shared_pin_is_data_o(pin_data),
    .row_program_blocked_o(blk), .dummy_cycles_o(dum),
    .wrap_at_burst_o(wrap), .burst_bytes_o(bb), .ready_o(rdy));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    fcr_host_model_i.send(op, d);
    w(8);
  endtask
  task automatic pulse(input logic s, input logic r);
    sus = s;
    res = r;
    w(1);
    sus = 1'b0;
    res = 1'b0;
    w(3);
  endtask
  task automatic do_rst(input logic s);
    rst = 1'b1;
    strap = s;
    w(12);
    rst = 1'b0;
    w(4);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {rst, ded, strap, quad, qpi, pb, eb, sus, res} = 9'h180;
    sel = 2'h0;
    do_rst(1'b0);
    chk(func, 8'h00);
    chk(rd, 8'h00);
    chk(8'(bb), 8'h08);
    chk(8'(rdy), 8'h01);
    wr(8'h65, 8'hab);
    chk(rdnv, 8'hab);
    chk(rd, 8'h00);
    wr(8'h99, 8'h55);
    chk(rdnv, 8'hab);
    chk(func, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = vals[i];
      wr(i[0] ? 8'h63 : 8'hc0, v);
      chk(rd, v);
      chk(8'(dum), 8'(v[6:3]));
      chk(8'(wrap), 8'(v[2]));
      chk(8'(bb), 8'(7'h08 << v[1:0]));
      chk(8'(pin_rst), 8'h00);
    end
    ded = 1'b0;
    w(3);
    chk(8'(pin_rst), 8'h01);
    quad = 1'b1;
    w(3);
    chk(8'({pin_data, pin_rst}), 8'h02);
    {quad, qpi} = 2'b01;
    w(3);
    chk(8'({pin_data, pin_rst}), 8'h02);
    {qpi, ded} = 2'b01;
    w(3);
    chk(8'(ded_act), 8'h01);
    wr(8'h42, 8'h01);
    chk(func, 8'h01);
    chk(8'({ded_act, pin_rst}), 8'h01);
    wr(8'h42, 8'h1e);
    chk(func, 8'h13);
    chk(8'(blk), 8'h01);
    sel = 2'h1;
    w(3);
    chk(8'(blk), 8'h00);
    wr(8'h42, 8'h00);
    chk(func, 8'h13);
    pb = 1'b1;
    pulse(1'b1, 1'b0);
    chk(func, 8'h17);
    pb = 1'b0;
    pulse(1'b0, 1'b1);
    chk(func, 8'h13);
    eb = 1'b1;
    pulse(1'b1, 1'b0);
    chk(func, 8'h1b);
    eb = 1'b0;
    pulse(1'b0, 1'b1);
    chk(func, 8'h13);
    eb = 1'b1;
    pulse(1'b1, 1'b0);
    eb = 1'b0;
    do_rst(1'b1);
    chk(func, 8'h01);
    chk(rd, 8'h00);
    end_of_test();
  end
endmodule
bind fcr_regs fcr_regs_sva fcr_regs_sva_i (.sys_clk_i, .sys_rst_i,
  .has_dedicated_reset_i, .quad_lines_on_i, .qpi_mode_i,
  .program_busy_i, .erase_busy_i, .suspend_cmd_i, .resume_cmd_i,
  .func_o, .read_o, .dedicated_reset_active_o, .shared_pin_is_reset_o,
  .shared_pin_is_data_o, .dummy_cycles_o, .wrap_at_burst_o,
  .burst_bytes_o);
